/* dv/odc_decoder_model.sv */
/* Behavioural bank of octal decoder matrices plus the two digit gates.
   Assumes the driver feeds selects, group enables, strobe and spare. */
`timescale 1ns/10ps
module odc_decoder_model #(
  parameter int N_DEC = 8
) (
  input wire logic [2:0] i_sel_true,
  input wire logic [2:0] i_sel_comp,
  input wire logic i_b3_true,
  input wire logic [N_DEC-1:0] i_grp_en,
  input wire logic i_strobe,
  input wire logic i_spare_en,
  output logic [N_DEC*8-1:0] o_line_n,
  output logic o_digit8_n,
  output logic o_digit9_n
);
  // ==========
  // Matrix gates
  // ==========
  always_comb
  begin
    for (int d = 0; d < N_DEC; d++)
      for (int k = 0; k < 8; k++)
        o_line_n[d*8+k] = !(i_grp_en[d] && i_strobe && i_spare_en &&
          (&((3'(k) & i_sel_true) | (~3'(k) & i_sel_comp))));
  end
  // Free gates wired for decimal use; only the top and bottom bits reach
  // them, so codes above nine give ambiguous lines.
  assign o_digit8_n = !(i_b3_true && i_sel_comp[0] && i_strobe);
  assign o_digit9_n = !(i_b3_true && i_sel_true[0] && i_strobe);
endmodule : odc_decoder_model

/* dv/odc_driver_properties.sv */
/* Port checks for the decoder matrix driver.
   Assumes the default settle, strobe and hold counts of 3, 5 and 3. */
`timescale 1ns/10ps
module odc_driver_properties #(
  parameter int N_DEC = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_bcd,
  input wire logic [5:0] i_code,
  input wire logic o_busy,
  input wire logic [2:0] o_sel_true,
  input wire logic [2:0] o_sel_comp,
  input wire logic o_b3_true,
  input wire logic o_b3_comp,
  input wire logic [N_DEC-1:0] o_grp_en,
  input wire logic o_strobe,
  input wire logic o_spare_en
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  // ==========
  // Assertions
  // ==========
  a_comp_pair: assert property (
    o_sel_comp == ~o_sel_true && o_b3_comp == ~o_b3_true)
    else $error("complement lines disagree");
  a_take_binary: assert property (i_req && !o_busy && !i_bcd |=> o_busy
    && o_sel_true == $past(i_code[2:0])
    && o_grp_en == (N_DEC'(1) << $past(i_code[5:3])))
    else $error("binary code not applied");
  a_take_bcd: assert property (i_req && !o_busy && i_bcd |=>
    o_b3_true == $past(i_code[3]) && o_grp_en == N_DEC'(!$past(i_code[3])))
    else $error("decimal code not applied");
  a_setup_quiet: assert property (
    $rose(o_busy) |-> !o_strobe[*4] ##1 o_strobe)
    else $error("strobe setup wrong");
  a_strobe_width: assert property (
    $rose(o_strobe) |-> o_strobe[*6] ##1 !o_strobe)
    else $error("strobe width wrong");
  a_hold_quiet: assert property (
    $fell(o_strobe) |-> o_busy[*4] ##1 !o_busy)
    else $error("hold phase wrong");
  a_sel_frozen: assert property (o_busy && $past(o_busy) |->
    $stable(o_sel_true) && $stable(o_grp_en))
    else $error("selects moved while busy");
  a_one_group: assert property ($onehot0(o_grp_en))
    else $error("more than one group enabled");
  a_spare_high: assert property (o_spare_en)
    else $error("spare enable low");
  a_strobe_busy: assert property (o_strobe |-> o_busy)
    else $error("strobe outside access");
  cover property ($rose(o_strobe));
  cover property (i_req && !o_busy && i_bcd);
  cover property (i_req && o_busy);
endmodule : odc_driver_properties
bind odc_driver odc_driver_properties #(.N_DEC(N_DEC)) u_props (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req(i_req), .i_bcd(i_bcd),
  .i_code(i_code), .o_busy(o_busy), .o_sel_true(o_sel_true),
  .o_sel_comp(o_sel_comp), .o_b3_true(o_b3_true), .o_b3_comp(o_b3_comp),
  .o_grp_en(o_grp_en), .o_strobe(o_strobe), .o_spare_en(o_spare_en));

/* dv/tb_odc_driver.sv */
/* Self-checking bench for the decoder matrix driver and decoder model.
   Assumes the driver's default timing parameters. */
`timescale 1ns/10ps
module tb_odc_driver;
  logic i_sys_clk, i_nrst, i_req, i_bcd, o_busy, o_b3_true, o_b3_comp;
  logic o_strobe, o_spare_en, dig8_n, dig9_n;
  logic [5:0] i_code;
  logic [2:0] o_sel_true, o_sel_comp;
  logic [7:0] o_grp_en;
  logic [63:0] line_n;
  logic [65:0] dec_out;
  int n_mismatch = 0;
  int check_count = 0;
  logic [5:0] codes [5] = '{6'h00, 6'h07, 6'h08, 6'h2a, 6'h3f};
  assign dec_out = {dig9_n, dig8_n, line_n};
  odc_driver dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req(i_req),
    .i_bcd(i_bcd), .i_code(i_code), .o_busy(o_busy),
    .o_sel_true(o_sel_true), .o_sel_comp(o_sel_comp),
    .o_b3_true(o_b3_true), .o_b3_comp(o_b3_comp), .o_grp_en(o_grp_en),
    .o_strobe(o_strobe), .o_spare_en(o_spare_en));
  odc_decoder_model u_dec (.i_sel_true(o_sel_true),
    .i_sel_comp(o_sel_comp), .i_b3_true(o_b3_true), .i_grp_en(o_grp_en),
    .i_strobe(o_strobe), .i_spare_en(o_spare_en), .o_line_n(line_n),
    .o_digit8_n(dig8_n), .o_digit9_n(dig9_n));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [65:0] seen, input logic [65:0] exp,
    input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ==========
  // Scenarios
  // ==========
  task automatic access(input logic bcd, input logic [5:0] code);
    int n;
    logic [65:0] exp;
    exp = '1;
    // The free gates stay wired to bit 3 and select bit 0 in binary mode
    // too, so an address with bit 3 set also pulls one digit line low.
    if (!bcd)
    begin
      exp[code] = 1'b0;
      if (code[3])
        exp[64 + code[0]] = 1'b0;
    end
    else if (code[3])
      exp[64 + code[0]] = 1'b0;
    else
      exp[code[2:0]] = 1'b0;
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_bcd <= bcd;
    i_code <= code;
    @(posedge i_sys_clk);
    i_req <= 1'b0;
    n = 0;
    @(negedge i_sys_clk);
    while (o_strobe !== 1'b1 && n < 20)
    begin
      check(dec_out, '1, "line low before strobe");
      n++;
      @(negedge i_sys_clk);
    end
    check(66'(n), 66'(4), "setup length");
    n = 0;
    while (o_strobe === 1'b1 && n < 20)
    begin
      check(dec_out, exp, "wrong selected line");
      n++;
      @(negedge i_sys_clk);
    end
    check(66'(n), 66'(6), "strobe length");
    n = 0;
    while (o_busy === 1'b1 && n < 20)
    begin
      check(dec_out, '1, "line low after strobe");
      n++;
      @(negedge i_sys_clk);
    end
    check(66'(n), 66'(4), "hold length");
    check(66'({o_b3_true, o_b3_comp}), 66'({code[3], !code[3]}),
      "digit bit lines");
  endtask : access
  task automatic refused();
    int n;
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_bcd <= 1'b0;
    i_code <= 6'h15;
    @(posedge i_sys_clk);
    i_code <= 6'h2e;
    @(posedge i_sys_clk);
    i_req <= 1'b0;
    n = 0;
    @(negedge i_sys_clk);
    while (o_busy === 1'b1 && n < 30)
    begin
      n++;
      @(negedge i_sys_clk);
    end
    check(66'(n), 66'(13), "busy length");
    check(66'({o_grp_en, o_sel_true}), 66'({8'h04, 3'h5}),
      "late request");
    @(negedge i_sys_clk);
    check(66'(o_busy), 66'(0), "late request started");
  endtask : refused
  initial
  begin
    i_nrst = 1'b0;
    i_req = 1'b0;
    i_bcd = 1'b0;
    i_code = 6'h00;
    repeat (5) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check(66'({o_busy, o_strobe, o_spare_en, o_b3_true, o_b3_comp,
      o_grp_en, o_sel_true, o_sel_comp}),
      66'({2'h0, 1'h1, 1'h0, 1'h1, 8'h00, 3'h0, 3'h7}),
      "reset values");
    check(dec_out, '1, "line low in reset");
    @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    foreach (codes[i])
      access(1'b0, codes[i]);
    for (int d = 0; d < 10; d++)
      access(1'b1, 6'(d));
    refused();
    print_verdict();
  end
  initial
  begin
    repeat (2000) @(posedge i_sys_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_odc_driver

/* inc/odc_pkg.sv */
/*
 * Types shared by the octal decoder matrix driver.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package odc_pkg;

  // ========================================================================
  // Sequencer states
  // ========================================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD = 4'b1000
  } odc_state_t;

endpackage : odc_pkg

/* inc/odc_regs.svh */
/*
 * Timing figures and reset values for the octal decoder matrix driver.
 * Assumes a 100 MHz system clock; every count is derived from ns figures.
 */
`ifndef ODC_REGS_SVH
`define ODC_REGS_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define ODC_CLK_PERIOD_PS 10000
// Select lines settle through the matrix gates before the strobe rises.
`define ODC_SETTLE_NS 30
// Least width of the strobe pulse on the shared enable line.
`define ODC_STROBE_NS 50
// Quiet time after the strobe falls before the selects may change.
`define ODC_HOLD_NS 30
// Least times round up to whole cycles; a figure of zero ns gives zero cycles.
`define ODC_CYC(ns) ((((ns) * 1000) + `ODC_CLK_PERIOD_PS - 1) / \
  `ODC_CLK_PERIOD_PS)
`define ODC_SETTLE_CYC `ODC_CYC(`ODC_SETTLE_NS)
`define ODC_STROBE_CYC `ODC_CYC(`ODC_STROBE_NS)
`define ODC_HOLD_CYC `ODC_CYC(`ODC_HOLD_NS)

// ==========================================================================
// Reset values of the pin drivers
// ==========================================================================
`define ODC_RST_SEL_TRUE 3'h0
`define ODC_RST_SEL_COMP 3'h7
`define ODC_RST_B3_TRUE 1'h0
`define ODC_RST_B3_COMP 1'h1
`define ODC_RST_GRP_EN 8'h00
`define ODC_RST_STROBE 1'h0
`define ODC_RST_SPARE_EN 1'h1

`endif

/* src/odc_driver.sv */
/*
 * Controller that drives one to eight octal decoder matrices through their
 * true/complement select lines and three enable lines per matrix, two of them shared.
 * Assumes the decoders are wired as a cascaded matrix: the selects and the
 * strobe line are common, the group enable line is one per decoder.
 */
`timescale 1ns/10ps
`include "odc_regs.svh"

module odc_driver
  import odc_pkg::*;
#(
  parameter int N_DEC = 8,
  parameter int CNT_W = 8,
  parameter logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(`ODC_SETTLE_CYC),
  parameter logic [CNT_W-1:0] STROBE_CYC = CNT_W'(`ODC_STROBE_CYC),
  parameter logic [CNT_W-1:0] HOLD_CYC = CNT_W'(`ODC_HOLD_CYC)
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_bcd,
  input wire logic [5:0] i_code,
  output logic o_busy,
  output logic [2:0] o_sel_true,
  output logic [2:0] o_sel_comp,
  output logic o_b3_true,
  output logic o_b3_comp,
  output logic [N_DEC-1:0] o_grp_en,
  output logic o_strobe,
  output logic o_spare_en
);

  odc_state_t state_reg;
  logic timer_load;
  logic [CNT_W-1:0] timer_count;
  logic timer_done;
  logic busy_reg;
  logic [2:0] sel_true_reg;
  logic [2:0] sel_comp_reg;
  logic b3_true_reg;
  logic b3_comp_reg;
  logic [N_DEC-1:0] grp_en_reg;
  logic strobe_reg;
  logic spare_en_reg;
  logic [N_DEC-1:0] grp_en_next;

  // ==========================================================================
  // Group enable decode
  // ==========================================================================
  // In binary mode the upper bits pick exactly one decoder; the others see a
  // ZERO on their group enable and stay inhibited. In decimal mode only
  // decoder 0 carries digits 0 to 7, so it is inhibited when bit 3 is set
  // and the two extra gates answer instead.
  always_comb
  begin
    grp_en_next = '0;
    for (int g = 0; g < N_DEC; g++)
    begin
      if (i_bcd)
      begin
        grp_en_next[g] = (g == 0) && !i_code[3];
      end
      else
      begin
        grp_en_next[g] = (i_code[5:3] == 3'(g));
      end
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (i_req)
          begin
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (timer_done)
          begin
            state_reg <= ST_STROBE;
          end
        end
        ST_STROBE:
        begin
          if (timer_done)
          begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (timer_done)
          begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    timer_load = 1'b0;
    timer_count = SETTLE_CYC;
    unique case (state_reg)
      ST_IDLE:
      begin
        timer_load = i_req;
        timer_count = SETTLE_CYC;
      end
      ST_SETUP:
      begin
        timer_load = timer_done;
        timer_count = STROBE_CYC;
      end
      ST_STROBE:
      begin
        timer_load = timer_done;
        timer_count = HOLD_CYC;
      end
      ST_HOLD:
      begin
        timer_load = 1'b0;
        timer_count = SETTLE_CYC;
      end
    endcase
  end

  odc_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_load(timer_load),
    .i_count(timer_count),
    .o_done(timer_done)
  );

  // ==========================================================================
  // Busy flag
  // ==========================================================================
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      busy_reg <= 1'b0;
    end
    else if (state_reg == ST_IDLE)
    begin
      busy_reg <= i_req;
    end
    else if (state_reg == ST_HOLD && timer_done)
    begin
      busy_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Select and group lines
  // ==========================================================================
  // These change only on request acceptance, while the strobe is low, so the
  // intermediate codes a switching register passes through never show up
  // as spikes on the decoder outputs.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      sel_true_reg <= `ODC_RST_SEL_TRUE;
      sel_comp_reg <= `ODC_RST_SEL_COMP;
      b3_true_reg <= `ODC_RST_B3_TRUE;
      b3_comp_reg <= `ODC_RST_B3_COMP;
      grp_en_reg <= N_DEC'(`ODC_RST_GRP_EN);
    end
    else if (state_reg == ST_IDLE && i_req)
    begin
      sel_true_reg <= i_code[2:0];
      sel_comp_reg <= ~i_code[2:0];
      // Only the most significant bit goes to the extra digit gates; the
      // least significant one is shared with the matrix select.
      b3_true_reg <= i_code[3];
      b3_comp_reg <= ~i_code[3];
      grp_en_reg <= grp_en_next;
    end
  end

  // ==========================================================================
  // Strobe and spare enable
  // ==========================================================================
  // The strobe rises only after the selects have settled and falls before
  // they may move again.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      strobe_reg <= `ODC_RST_STROBE;
    end
    else if (state_reg == ST_SETUP && timer_done)
    begin
      strobe_reg <= 1'b1;
    end
    else if (state_reg == ST_STROBE && timer_done)
    begin
      strobe_reg <= 1'b0;
    end
  end

  // The third shared enable is held at ONE; it is free for another strobe.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      spare_en_reg <= `ODC_RST_SPARE_EN;
    end
    else
    begin
      spare_en_reg <= 1'b1;
    end
  end

  assign o_busy = busy_reg;
  assign o_sel_true = sel_true_reg;
  assign o_sel_comp = sel_comp_reg;
  assign o_b3_true = b3_true_reg;
  assign o_b3_comp = b3_comp_reg;
  assign o_grp_en = grp_en_reg;
  assign o_strobe = strobe_reg;
  assign o_spare_en = spare_en_reg;

endmodule : odc_driver

/* src/odc_timer.sv */
/*
 * Down counter that times the phases of one decoder access.
 * Assumes the load pulse and count come from the sequencer in odc_driver.
 */
`timescale 1ns/10ps

module odc_timer #(
  parameter int CNT_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_count,
  output logic o_done
);

  logic [CNT_W-1:0] cnt_reg;

  // ========================================================================
  // Counter
  // ========================================================================
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      cnt_reg <= '0;
    end
    else if (i_load)
    begin
      cnt_reg <= i_count;
    end
    else if (cnt_reg != '0)
    begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign o_done = (cnt_reg == '0);

endmodule : odc_timer
